// File: verilog/ccs_consts.svh
// Constants for the CPU clock source switch: bit positions, reset values, wait counts.
// Assumes inclusion by bare name from the switch module only.
`ifndef CCS_CONSTS_SVH
`define CCS_CONSTS_SVH

// =====================================================================
// Register image bit positions
`define CCS_MCM_SEL_BIT      0
`define CCS_MCM_STS_BIT      1
`define CCS_PCC_DIV_LSB      0
`define CCS_PCC_DIV_MSB      2
`define CCS_PCC_CSS_BIT      4
`define CCS_PCC_CLS_BIT      5
`define CCS_PCC_STOP_BIT     7
`define CCS_MOC_STOP_BIT     7
`define CCS_RCM_STOP_BIT     0

// =====================================================================
// Reset values
`define CCS_DIV_RST          3'h0
`define CCS_STAB_SEL_RST     3'h4
`define CCS_IMG_RST          8'h00

// =====================================================================
// Switch wait counts, in CPU clocks of the source in use before the switch
`define CCS_HS_INT_RATIO     16'h0085
`define CCS_SUB_ENTRY_BASE   16'h03D1
`define CCS_WAIT_TO_HS       16'h0002
`define CCS_WAIT_FROM_SUB    16'h0002
`define CCS_WAIT_DIV_BASE    16'h0010
`define CCS_DIV_FASTEST      3'h4

`endif

// File: verilog/ccs_pkg.sv
// Types for the CPU clock source switch.
// Assumes nothing of its surroundings.
`default_nettype none

package ccs_pkg;

   // =====================================================================
   // Clock source in use
   typedef enum logic [1:0] {
      CCS_SRC_INT = 2'b00,
      CCS_SRC_HS  = 2'b01,
      CCS_SRC_SUB = 2'b10
   } ccs_src_t;

   // =====================================================================
   // Switch sequencer states
   typedef enum logic [0:0] {
      CCS_ST_IDLE = 1'b0,
      CCS_ST_WAIT = 1'b1
   } ccs_state_t;

endpackage : ccs_pkg

`default_nettype wire

// File: verilog/ccs_clock_switch.sv
// CPU clock source switch: internal, high-speed and subsystem sources plus division.
// Assumes control bits and CPU_CLK_TICK come from logic on SYS_CLK, so no synchronisers.
`include "ccs_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// Every clocked process below is frozen while CLK_EN is low, reset excepted, so a
// frozen block still returns to the internal source on a reset request.
// Switch waits are counted only by CPU_CLK_TICK, never by SYS_CLK, because
// the CPU clock of the source in use is slower than the system clock.
module ccs_clock_switch (
   // Clock, reset and enable
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   input  wire logic        CLK_EN,
   // One pulse per CPU clock of the source in use
   input  wire logic        CPU_CLK_TICK,
   // Software control bits
   input  wire logic        MAIN_CLK_SELECT,
   input  wire logic [2:0]  CPU_DIV,
   input  wire logic        SUBSYS_SELECT,
   input  wire logic        HS_OSC_STOP_PROC,
   input  wire logic        HS_OSC_STOP_MAIN,
   input  wire logic        INT_OSC_STOP,
   // Stabilization handling
   input  wire logic        STAB_TIME_STATUS,
   input  wire logic [2:0]  STAB_TIME_SELECT,
   input  wire logic        STOP_RELEASE_IRQ,
   // Status
   output logic             MAIN_CLK_STATUS,
   output logic             SUBSYS_STATUS,
   output logic [1:0]       CPU_SRC,
   output logic [2:0]       CPU_DIV_ACTIVE,
   output logic             SWITCH_BUSY,
   // Oscillator enables
   output logic             HS_OSC_RUN,
   output logic             INT_OSC_RUN,
   output logic [2:0]       STAB_TIME_ACTIVE,
   // Register read images
   output logic [7:0]       MAIN_CLOCK_MODE_REG,
   output logic [7:0]       PROCESSOR_CLOCK_CTRL_REG,
   output logic [7:0]       MAIN_OSC_CTRL_REG,
   output logic [7:0]       INT_OSC_MODE_REG
);

   // =====================================================================
   // Declarations
   ccs_pkg::ccs_state_t state_reg;
   ccs_pkg::ccs_src_t   src_reg;
   ccs_pkg::ccs_src_t   pend_src_reg;
   ccs_pkg::ccs_src_t   tgt_src;
   logic [2:0]          div_reg;
   logic [2:0]          pend_div_reg;
   logic [15:0]         cnt_reg;
   logic [15:0]         wait_next;
   logic                legal;
   logic                stab_ok;
   logic                start_req;
   logic                done;
   logic                hs_run_next;

   // =====================================================================
   // Wait count for a switch, from the old state
   function automatic logic [15:0] calc_wait(
      input ccs_pkg::ccs_src_t cur,
      input ccs_pkg::ccs_src_t tgt,
      input logic [2:0]        div_old
   );
      logic [2:0]  d;
      logic [15:0] mask;
      logic [15:0] res;
      d    = (div_old > `CCS_DIV_FASTEST) ? `CCS_DIV_FASTEST : div_old;
      mask = (16'h0001 << d) - 16'h0001;
      if (cur == ccs_pkg::CCS_SRC_SUB) begin
         res = `CCS_WAIT_FROM_SUB;
      end else if (tgt == ccs_pkg::CCS_SRC_SUB) begin
         res = (`CCS_SUB_ENTRY_BASE + mask) >> d;
      end else if (cur == ccs_pkg::CCS_SRC_HS && tgt == ccs_pkg::CCS_SRC_INT) begin
         res = (`CCS_HS_INT_RATIO >> d) + 16'h0001;
      end else if (cur == ccs_pkg::CCS_SRC_INT && tgt == ccs_pkg::CCS_SRC_HS) begin
         res = `CCS_WAIT_TO_HS;
      end else begin
         res = `CCS_WAIT_DIV_BASE >> d;
      end
      calc_wait = res;
   endfunction : calc_wait

   // =====================================================================
   // Requested source from the control bits
   always_comb begin
      if (SUBSYS_SELECT) begin
         tgt_src = ccs_pkg::CCS_SRC_SUB;
      end else if (MAIN_CLK_SELECT) begin
         tgt_src = ccs_pkg::CCS_SRC_HS;
      end else begin
         tgt_src = ccs_pkg::CCS_SRC_INT;
      end
   end

   // Subsystem only touches high-speed; an illegal request is simply held off
   assign legal = !((tgt_src == ccs_pkg::CCS_SRC_SUB && src_reg == ccs_pkg::CCS_SRC_INT) ||
                    (src_reg == ccs_pkg::CCS_SRC_SUB && tgt_src == ccs_pkg::CCS_SRC_INT));

   // Leaving the internal oscillator waits for the high-speed clock to settle
   assign stab_ok = !(src_reg == ccs_pkg::CCS_SRC_INT && tgt_src == ccs_pkg::CCS_SRC_HS)
                    || STAB_TIME_STATUS;

   // A switch starts when the request differs from what is applied
   assign start_req = (state_reg == ccs_pkg::CCS_ST_IDLE) && legal && stab_ok &&
                      ((tgt_src != src_reg) || (CPU_DIV != div_reg));

   // The last tick of the old clock completes the switch
   assign done = (state_reg == ccs_pkg::CCS_ST_WAIT) && CPU_CLK_TICK &&
                 (cnt_reg == 16'h0001);

   assign wait_next = calc_wait(src_reg, tgt_src, div_reg);

   // =====================================================================
   // Sequencer state
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         state_reg <= ccs_pkg::CCS_ST_IDLE;
      end else if (CLK_EN) begin
         case (state_reg)
            ccs_pkg::CCS_ST_IDLE: begin
               if (start_req) begin
                  state_reg <= ccs_pkg::CCS_ST_WAIT;
               end
            end
            ccs_pkg::CCS_ST_WAIT: begin
               if (done) begin
                  state_reg <= ccs_pkg::CCS_ST_IDLE;
               end
            end
            default: begin
               state_reg <= ccs_pkg::CCS_ST_IDLE;
            end
         endcase
      end
   end

   // =====================================================================
   // Pending target, captured once so later writes wait for the next switch
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         pend_src_reg <= ccs_pkg::CCS_SRC_INT;
         pend_div_reg <= `CCS_DIV_RST;
      end else if (CLK_EN && start_req) begin
         pend_src_reg <= tgt_src;
         pend_div_reg <= CPU_DIV;
      end
   end

   // =====================================================================
   // Wait counter, stepped only by ticks of the clock still in use
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         cnt_reg <= 16'h0000;
      end else if (CLK_EN) begin
         if (start_req) begin
            cnt_reg <= wait_next;
         end else if (state_reg == ccs_pkg::CCS_ST_WAIT && CPU_CLK_TICK) begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end

   // =====================================================================
   // Applied source and division, updated only at completion
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         src_reg <= ccs_pkg::CCS_SRC_INT;
         div_reg <= `CCS_DIV_RST;
      end else if (CLK_EN && done) begin
         src_reg <= pend_src_reg;
         div_reg <= pend_div_reg;
      end
   end

   // =====================================================================
   // Status flags follow completion, never the control write
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         MAIN_CLK_STATUS <= 1'b0;
         SUBSYS_STATUS   <= 1'b0;
      end else if (CLK_EN && done) begin
         MAIN_CLK_STATUS <= (pend_src_reg != ccs_pkg::CCS_SRC_INT);
         SUBSYS_STATUS   <= (pend_src_reg == ccs_pkg::CCS_SRC_SUB);
      end
   end

   // =====================================================================
   // Applied source and division as outputs, updated with the status pair
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         CPU_SRC        <= ccs_pkg::CCS_SRC_INT;
         CPU_DIV_ACTIVE <= `CCS_DIV_RST;
      end else if (CLK_EN && done) begin
         CPU_SRC        <= pend_src_reg;
         CPU_DIV_ACTIVE <= pend_div_reg;
      end
   end

   // =====================================================================
   // Busy flag, high from start until the completing tick
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         SWITCH_BUSY <= 1'b0;
      end else if (CLK_EN) begin
         if (start_req) begin
            SWITCH_BUSY <= 1'b1;
         end else if (done) begin
            SWITCH_BUSY <= 1'b0;
         end
      end
   end

   // =====================================================================
   // High-speed oscillator stop: which bit counts depends on the source
   always_comb begin
      case (src_reg)
         ccs_pkg::CCS_SRC_HS:  hs_run_next = 1'b1;
         ccs_pkg::CCS_SRC_INT: hs_run_next = !HS_OSC_STOP_MAIN;
         ccs_pkg::CCS_SRC_SUB: hs_run_next = !HS_OSC_STOP_PROC;
         default:              hs_run_next = 1'b1;
      endcase
   end

   // High-speed enable; a switch in flight keeps high-speed running too
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         HS_OSC_RUN <= 1'b1;
      end else if (CLK_EN) begin
         HS_OSC_RUN <= hs_run_next || SWITCH_BUSY;
      end
   end

   // Internal enable; its stop bit is ignored while it clocks the CPU,
   // since stopping it then would leave the CPU with no clock at all
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         INT_OSC_RUN <= 1'b1;
      end else if (CLK_EN) begin
         INT_OSC_RUN <= !INT_OSC_STOP || (src_reg == ccs_pkg::CCS_SRC_INT);
      end
   end

   // =====================================================================
   // Stabilization selection is adopted only on stop release during high-speed
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         STAB_TIME_ACTIVE <= `CCS_STAB_SEL_RST;
      end else if (CLK_EN && STOP_RELEASE_IRQ && src_reg == ccs_pkg::CCS_SRC_HS) begin
         STAB_TIME_ACTIVE <= STAB_TIME_SELECT;
      end
   end

   // =====================================================================
   // Main clock mode image; status comes from the completed state
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         MAIN_CLOCK_MODE_REG <= `CCS_IMG_RST;
      end else if (CLK_EN) begin
         MAIN_CLOCK_MODE_REG <= `CCS_IMG_RST;
         MAIN_CLOCK_MODE_REG[`CCS_MCM_SEL_BIT] <= MAIN_CLK_SELECT;
         MAIN_CLOCK_MODE_REG[`CCS_MCM_STS_BIT] <= (src_reg != ccs_pkg::CCS_SRC_INT);
      end
   end

   // =====================================================================
   // Processor clock control image; written bits as set, status as applied
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         PROCESSOR_CLOCK_CTRL_REG <= `CCS_IMG_RST;
      end else if (CLK_EN) begin
         PROCESSOR_CLOCK_CTRL_REG <= `CCS_IMG_RST;
         PROCESSOR_CLOCK_CTRL_REG[`CCS_PCC_DIV_MSB:`CCS_PCC_DIV_LSB] <= CPU_DIV;
         PROCESSOR_CLOCK_CTRL_REG[`CCS_PCC_CSS_BIT] <= SUBSYS_SELECT;
         PROCESSOR_CLOCK_CTRL_REG[`CCS_PCC_CLS_BIT] <= (src_reg == ccs_pkg::CCS_SRC_SUB);
         PROCESSOR_CLOCK_CTRL_REG[`CCS_PCC_STOP_BIT] <= HS_OSC_STOP_PROC;
      end
   end

   // =====================================================================
   // Main oscillator control image
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         MAIN_OSC_CTRL_REG <= `CCS_IMG_RST;
      end else if (CLK_EN) begin
         MAIN_OSC_CTRL_REG <= `CCS_IMG_RST;
         MAIN_OSC_CTRL_REG[`CCS_MOC_STOP_BIT] <= HS_OSC_STOP_MAIN;
      end
   end

   // =====================================================================
   // Internal oscillator mode image
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         INT_OSC_MODE_REG <= `CCS_IMG_RST;
      end else if (CLK_EN) begin
         INT_OSC_MODE_REG <= `CCS_IMG_RST;
         INT_OSC_MODE_REG[`CCS_RCM_STOP_BIT] <= INT_OSC_STOP;
      end
   end

endmodule : ccs_clock_switch

`default_nettype wire

// File: test/ccs_clock_switch_sva.sv
// Checker for the CPU clock source switch: status timing, legal paths, oscillator enables.
// Assumes it is bound into the switch module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module ccs_clock_switch_sva (
   // Clock and reset
   input wire logic       SYS_CLK,
   input wire logic       RSTN,
   input wire logic       CLK_EN,
   // Control inputs
   input wire logic       CPU_CLK_TICK,
   input wire logic       MAIN_CLK_SELECT,
   input wire logic       SUBSYS_SELECT,
   input wire logic       HS_OSC_STOP_PROC,
   input wire logic       HS_OSC_STOP_MAIN,
   // Observed outputs
   input wire logic       MAIN_CLK_STATUS,
   input wire logic       SUBSYS_STATUS,
   input wire logic [1:0] CPU_SRC,
   input wire logic [2:0] CPU_DIV_ACTIVE,
   input wire logic       SWITCH_BUSY,
   input wire logic       HS_OSC_RUN,
   input wire logic       INT_OSC_RUN,
   input wire logic [7:0] MAIN_CLOCK_MODE_REG
);
   // =====================================================================
   // One domain, so one clock and one disable for all
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   // Status pair must always match the source in use
   a_status_pair: assert property (MAIN_CLK_STATUS == (CPU_SRC != 2'h0) && SUBSYS_STATUS == (CPU_SRC == 2'h2))
      else $error("status pair disagrees with source");
   // Source and division move only when a wait ends
   a_src_at_done: assert property ($changed(CPU_SRC) |-> $fell(SWITCH_BUSY))
      else $error("source changed outside completion");
   a_div_at_done: assert property ($changed(CPU_DIV_ACTIVE) |-> !SWITCH_BUSY && $past(SWITCH_BUSY))
      else $error("division changed outside completion");
   // Subsystem is reached and left through high-speed only
   a_legal_path: assert property ($changed(CPU_SRC) |-> CPU_SRC == 2'h1 || $past(CPU_SRC) == 2'h1)
      else $error("illegal source transition");
   // A wait ends only on a sampled CPU clock tick
   a_done_on_tick: assert property ($fell(SWITCH_BUSY) |-> $past(CPU_CLK_TICK) && $past(CLK_EN))
      else $error("switch completed without a tick");
   // Stop bits cannot halt the source in use, nor high-speed while a switch is in flight
   a_hs_kept: assert property (CLK_EN && (CPU_SRC == 2'h1 || SWITCH_BUSY) |=> HS_OSC_RUN)
      else $error("high-speed oscillator stopped while needed");
   a_int_main_stop: assert property (CLK_EN && CPU_SRC == 2'h0 && !SWITCH_BUSY && !MAIN_CLK_SELECT |=>
      HS_OSC_RUN == !$past(HS_OSC_STOP_MAIN))
      else $error("internal mode stop not taken from main stop bit");
   a_sub_proc_stop: assert property (CLK_EN && CPU_SRC == 2'h2 && !SWITCH_BUSY && SUBSYS_SELECT |=>
      HS_OSC_RUN == !$past(HS_OSC_STOP_PROC))
      else $error("subsystem mode stop not taken from processor stop bit");
   a_int_osc_on: assert property (CLK_EN && CPU_SRC == 2'h0 |=> INT_OSC_RUN)
      else $error("internal oscillator stopped while in use");
   // Mode image lags its inputs by one enabled edge
   a_mode_image: assert property (CLK_EN |=> MAIN_CLOCK_MODE_REG ==
      {6'h00, $past(MAIN_CLK_STATUS), $past(MAIN_CLK_SELECT)})
      else $error("mode image wrong");
endmodule : ccs_clock_switch_sva

bind ccs_clock_switch ccs_clock_switch_sva ccs_clock_switch_sva_i (.SYS_CLK, .RSTN, .CLK_EN,
   .CPU_CLK_TICK, .MAIN_CLK_SELECT, .SUBSYS_SELECT, .HS_OSC_STOP_PROC, .HS_OSC_STOP_MAIN,
   .MAIN_CLK_STATUS, .SUBSYS_STATUS, .CPU_SRC, .CPU_DIV_ACTIVE, .SWITCH_BUSY, .HS_OSC_RUN,
   .INT_OSC_RUN, .MAIN_CLOCK_MODE_REG);

`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the CPU clock source switch.
// Assumes the package, the switch module and its checker are compiled first.
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // =====================================================================
   // Design connections and bench state
   logic       SYS_CLK, RSTN, CLK_EN, CPU_CLK_TICK, MAIN_CLK_SELECT, SUBSYS_SELECT;
   logic       HS_OSC_STOP_PROC, HS_OSC_STOP_MAIN, INT_OSC_STOP, STAB_TIME_STATUS;
   logic       STOP_RELEASE_IRQ, MAIN_CLK_STATUS, SUBSYS_STATUS, SWITCH_BUSY;
   logic       HS_OSC_RUN, INT_OSC_RUN;
   logic [2:0] CPU_DIV, STAB_TIME_SELECT, CPU_DIV_ACTIVE, STAB_TIME_ACTIVE, cur_div;
   logic [1:0] CPU_SRC, cur_src;
   logic [7:0] MAIN_CLOCK_MODE_REG, PROCESSOR_CLOCK_CTRL_REG, MAIN_OSC_CTRL_REG, INT_OSC_MODE_REG;
   int         miscompares, checks, i;

   ccs_clock_switch ccs_clock_switch_i (.SYS_CLK, .RSTN, .CLK_EN, .CPU_CLK_TICK,
      .MAIN_CLK_SELECT, .CPU_DIV, .SUBSYS_SELECT, .HS_OSC_STOP_PROC, .HS_OSC_STOP_MAIN,
      .INT_OSC_STOP, .STAB_TIME_STATUS, .STAB_TIME_SELECT, .STOP_RELEASE_IRQ,
      .MAIN_CLK_STATUS, .SUBSYS_STATUS, .CPU_SRC, .CPU_DIV_ACTIVE, .SWITCH_BUSY,
      .HS_OSC_RUN, .INT_OSC_RUN, .STAB_TIME_ACTIVE, .MAIN_CLOCK_MODE_REG,
      .PROCESSOR_CLOCK_CTRL_REG, .MAIN_OSC_CTRL_REG, .INT_OSC_MODE_REG);

   // 40 MHz system clock
   initial begin
      SYS_CLK = 1'b0;
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end

   // =====================================================================
   // Expected wait in old CPU clocks; 133 is the high-speed to internal ratio
   function automatic int exp_wait(logic [1:0] from, logic [1:0] to, logic [2:0] d);
      if (from == 2'h2) return 2;
      if (to == 2'h2) return (977 + (1 << d) - 1) >> d;
      if (from != to) return (from == 2'h1) ? (133 >> d) + 1 : 2;
      return 16 >> d;
   endfunction : exp_wait

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Request a switch, tick until done, compare count and status; refused ones expect 0
   task automatic go(input logic sel, input logic sub, input logic [2:0] div_in);
      logic [1:0] tgt;
      logic [2:0] div;
      int         n, t, exp_n;
      tgt = sub ? 2'h2 : {1'b0, sel};
      div = div_in;
      exp_n = exp_wait(cur_src, tgt, cur_div);
      if ((tgt == cur_src && div == cur_div) || (tgt != cur_src && tgt + cur_src == 2'h2)
          || (cur_src == 2'h0 && tgt == 2'h1 && !STAB_TIME_STATUS)) begin
         exp_n = 0;
         tgt = cur_src;
         div = cur_div;
      end
      n = 0;
      t = 0;
      MAIN_CLK_SELECT = sel;
      SUBSYS_SELECT = sub;
      CPU_DIV = div_in;
      @(negedge SYS_CLK);
      while (SWITCH_BUSY !== 1'b1 && t < 6) begin
         @(negedge SYS_CLK);
         t++;
      end
      // Ticks never back to back: a CPU clock is not faster than the system clock
      while (SWITCH_BUSY === 1'b1 && t < 6000) begin
         CPU_CLK_TICK = CPU_CLK_TICK ? 1'b0 : 1'($urandom % 2);
         @(posedge SYS_CLK);
         n += CPU_CLK_TICK;
         @(negedge SYS_CLK);
         t++;
      end
      CPU_CLK_TICK = 1'b0;
      check({CPU_SRC, CPU_DIV_ACTIVE, SUBSYS_STATUS, MAIN_CLK_STATUS, 12'(n)},
            {tgt, div, tgt[1], tgt != 2'h0, 12'(exp_n)});
      cur_src = tgt;
      cur_div = div;
   endtask : go

   task automatic give_verdict;
      if (miscompares == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : give_verdict

   // Watchdog well beyond the expected run of under 10000 cycles
   initial begin
      #(40000 * 25);
      miscompares++;
      give_verdict();
   end

   // =====================================================================
   // Main sequence
   initial begin
      i = $urandom(32'h85A5);
      {RSTN, CLK_EN, CPU_CLK_TICK, MAIN_CLK_SELECT, SUBSYS_SELECT, CPU_DIV} = 8'h40;
      {HS_OSC_STOP_PROC, HS_OSC_STOP_MAIN, INT_OSC_STOP, STAB_TIME_STATUS} = 4'h0;
      {STAB_TIME_SELECT, STOP_RELEASE_IRQ, cur_src, cur_div} = 9'h000;
      miscompares = 0;
      checks = 0;
      repeat (5) @(negedge SYS_CLK);
      check({CPU_SRC, MAIN_CLK_STATUS, SUBSYS_STATUS, SWITCH_BUSY, HS_OSC_RUN, INT_OSC_RUN,
             STAB_TIME_ACTIVE, CPU_DIV_ACTIVE}, 32'h0000_00E0);
      RSTN = 1'b1;
      go(1'b1, 1'b0, 3'h0);
      STAB_TIME_STATUS = 1'b1;
      go(1'b1, 1'b0, 3'h0);
      for (i = 1; i < 6; i++) go(1'b1, 1'b0, 3'(i % 5));
      for (i = 0; i < 5; i++) begin
         go(1'b1, 1'b0, 3'(i));
         go(1'b1, 1'b1, 3'(i));
         {HS_OSC_STOP_MAIN, HS_OSC_STOP_PROC} = 2'($urandom % 4);
         go(1'b1, 1'b1, 3'(i));
         check(HS_OSC_RUN, !HS_OSC_STOP_PROC);
         go(1'b1, 1'b0, 3'($urandom % 5));
      end
      {HS_OSC_STOP_MAIN, HS_OSC_STOP_PROC} = 2'h0;
      go(1'b1, 1'b0, 3'h0);
      go(1'b0, 1'b0, 3'h0);
      go(1'b1, 1'b0, 3'h1);
      go(1'b0, 1'b0, 3'h1);
      // On internal: processor stop and release interrupt have no effect
      {HS_OSC_STOP_PROC, INT_OSC_STOP, STOP_RELEASE_IRQ} = 3'h7;
      STAB_TIME_SELECT = 3'($urandom % 4);
      @(negedge SYS_CLK);
      check({HS_OSC_RUN, INT_OSC_RUN, STAB_TIME_ACTIVE}, {2'h3, 3'h4});
      check({MAIN_CLOCK_MODE_REG, PROCESSOR_CLOCK_CTRL_REG, MAIN_OSC_CTRL_REG, INT_OSC_MODE_REG},
            32'h0081_0001);
      {STOP_RELEASE_IRQ, HS_OSC_STOP_MAIN} = 2'h1;
      @(negedge SYS_CLK);
      check(HS_OSC_RUN, 1'b0);
      check(MAIN_OSC_CTRL_REG, 8'h80);
      {HS_OSC_STOP_MAIN, HS_OSC_STOP_PROC} = 2'h0;
      go(1'b1, 1'b0, 3'h1);
      STAB_TIME_SELECT = 3'($urandom % 8);
      STOP_RELEASE_IRQ = 1'b1;
      @(negedge SYS_CLK);
      STOP_RELEASE_IRQ = 1'b0;
      @(negedge SYS_CLK);
      check({STAB_TIME_ACTIVE, INT_OSC_RUN, MAIN_CLOCK_MODE_REG},
            {STAB_TIME_SELECT, 1'b0, 8'h03});
      // Enable low freezes state: a release pulse then must not be adopted
      CLK_EN = 1'b0;
      STAB_TIME_SELECT = ~STAB_TIME_SELECT;
      STOP_RELEASE_IRQ = 1'b1;
      @(negedge SYS_CLK);
      STOP_RELEASE_IRQ = 1'b0;
      CLK_EN = 1'b1;
      @(negedge SYS_CLK);
      check({STAB_TIME_ACTIVE, INT_OSC_RUN}, {~STAB_TIME_SELECT, 1'b0});
      give_verdict();
   end
endmodule : testbench

`default_nettype wire
